// *** shared/sar_seq_pkg.sv ***
package sar_seq_pkg;
   // register map, byte addresses
   localparam int ADDR_W = 4;
   localparam logic [3:0] CFG_OFS = 4'h0;
   localparam logic [3:0] CMD_OFS = 4'h4;
   localparam logic [3:0] STAT_OFS = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // config_word fields
   localparam int CFG_CHAN_AUTO_POS = 11;
   localparam int CFG_TRIG_SRC_POS = 9;
   localparam int CFG_RATE_POS = 8;
   localparam int CFG_AUTO_SLEEP_POS = 1;
   localparam int CFG_CLK_SRC_POS = 0;
   localparam logic [31:0] CFG_RESET = 32'h0000_0A00;
   localparam logic [31:0] CFG_WMASK = 32'h0000_0B03;
   // command_word and status fields
   localparam int CHAN_W = 3;
   localparam int CMD_CHAN_LSB = 0;
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_READY_POS = 1;
   localparam int STAT_CUR_LSB = 4;
   localparam int STAT_LAST_LSB = 8;
   localparam int STAT_CNT_LSB = 16;
   localparam int CNT_W = 16;
   localparam logic [CHAN_W-1:0] CHAN_HI = 3'h7;
   // sequence lengths in conversion clocks
   localparam int SEQ_W = 5;
   localparam logic [SEQ_W-1:0] ACQ_CCLKS = 5'h03;
   localparam logic [SEQ_W-1:0] CONV_CCLKS = 5'h12;
   localparam logic [SEQ_W-1:0] SLOW_EXTRA_CCLKS = 5'h15;
   localparam logic [SEQ_W-1:0] ACQ_SLOW_CCLKS = ACQ_CCLKS + SLOW_EXTRA_CCLKS;
   // internal oscillator: slowest allowed period, rounded down to clocks
   localparam int CLK_PERIOD_PS = 25000;
   localparam int OSC_MAX_PERIOD_PS = 95238;
   localparam int OSC_DIV_W = 2;
   localparam logic [OSC_DIV_W-1:0] OSC_DIV =
      OSC_DIV_W'(OSC_MAX_PERIOD_PS / CLK_PERIOD_PS);

   typedef enum logic [1:0] {
      ST_ACQ = 2'b00,
      ST_READY = 2'b01,
      ST_CONV = 2'b10
   } seq_state_e;

   function automatic logic [CHAN_W-1:0] next_chan(
      input logic [CHAN_W-1:0] cur,
      input logic [CHAN_W-1:0] first);
      next_chan = (cur == CHAN_HI) ? first : cur + 3'h1;
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = data[i*8 +: 8];
      end
      apply_strb = res;
   endfunction
endpackage

// *** shared/conv_clock_if.sv ***
`timescale 1ns/1ps
interface conv_clock_if;
   logic osc_run;
   logic use_sclk;
   logic sclk_rise;
   logic tick;
   logic conv_clk;
   modport gen (input osc_run, input use_sclk, input sclk_rise,
      output tick, output conv_clk);
   modport user (output osc_run, output use_sclk, output sclk_rise,
      input tick, input conv_clk);
endinterface

// *** hw/conv_clock_gen.sv ***
`timescale 1ns/1ps
module conv_clock_gen import sar_seq_pkg::*; (
   input wire logic clk_in,
   input wire logic rstn_in,
   conv_clock_if.gen cc
);
   logic [OSC_DIV_W-1:0] div_r;
   logic clk_r;
   logic tick_r;

   assign cc.tick = tick_r;
   assign cc.conv_clk = clk_r;

   // source select and divider
   // clock source select
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         div_r <= '0;
         clk_r <= 1'b0;
         tick_r <= 1'b0;
      end
      else if (cc.use_sclk)
      begin
         div_r <= '0;
         tick_r <= 1'b0;
         if (cc.sclk_rise)
         begin
            clk_r <= ~clk_r;
            tick_r <= ~clk_r;
         end
      end
      else if (cc.osc_run)
      begin
         div_r <= (div_r == OSC_DIV - 2'h1) ? '0 : div_r + 2'h1;
         clk_r <= (div_r == OSC_DIV - 2'h1);
         tick_r <= (div_r == OSC_DIV - 2'h1);
      end
      else
      begin
         div_r <= '0;
         clk_r <= 1'b0;
         tick_r <= 1'b0;
      end
   end

   sclk_div_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (cc.use_sclk && cc.sclk_rise) |=> (clk_r != $past(clk_r)))
      else $error("conversion clock missed a serial clock toggle");

   osc_stop_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (!cc.use_sclk && !cc.osc_run) |=> !tick_r)
      else $error("oscillator ticked while stopped");
endmodule // conv_clock_gen

// *** hw/sar_conversion_sequencer.sv ***
`timescale 1ns/1ps
module sar_conversion_sequencer import sar_seq_pkg::*; (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [ADDR_W-1:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [ADDR_W-1:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   input wire logic sample_start_n_in,
   input wire logic sclk_in,
   input wire logic frame_select_n_in,
   output logic osc_run_out,
   output logic conv_clock_out,
   output logic hold_out,
   output logic conv_done_out,
   output logic [CHAN_W-1:0] chan_out
);
   logic [2:0] start_sync_r;
   logic [2:0] sclk_sync_r;
   logic start_fall;
   logic sclk_rise;
   logic [31:0] config_word_r;
   logic [CHAN_W-1:0] command_word_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic do_write;
   logic cmd_wr;
   seq_state_e state_r;
   logic [SEQ_W-1:0] cnt_r;
   logic [SEQ_W-1:0] acq_target;
   logic [CHAN_W-1:0] conv_chan_r;
   logic [CHAN_W-1:0] last_chan_r;
   logic [CHAN_W-1:0] scan_first_r;
   logic auto_prev_r;
   logic [CNT_W-1:0] conv_count_r;
   logic conv_end;
   logic conv_begin;
   logic chan_auto;
   logic trig_manual;
   logic osc_run_nxt;

   conv_clock_if cc_if ();

   conv_clock_gen u_clk_gen (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .cc(cc_if.gen)
   );

   assign cc_if.osc_run = osc_run_out;
   assign cc_if.use_sclk = config_word_r[CFG_CLK_SRC_POS];
   assign cc_if.sclk_rise = sclk_rise;
   assign conv_clock_out = cc_if.conv_clk;

   assign chan_auto = config_word_r[CFG_CHAN_AUTO_POS];
   assign trig_manual = config_word_r[CFG_TRIG_SRC_POS];

   // pin synchronisers, edge taken from the second and third stages
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         start_sync_r <= 3'h7;
         sclk_sync_r <= 3'h0;
      end
      else
      begin
         start_sync_r <= {start_sync_r[1:0], sample_start_n_in};
         sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
      end
   end

   assign start_fall = start_sync_r[2] & ~start_sync_r[1];
   assign sclk_rise = ~sclk_sync_r[2] & sclk_sync_r[1];

   // write channel: address and data taken in either order
   assign do_write = !awready_out && !wready_out && !bvalid_out;
   assign cmd_wr = do_write && (aw_addr_r == CMD_OFS) && w_strb_r[0];

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         awready_out <= 1'b1;
         wready_out <= 1'b1;
         bvalid_out <= 1'b0;
         bresp_out <= RESP_OKAY;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end
      else
      begin
         if (awvalid_in && awready_out)
         begin
            awready_out <= 1'b0;
            aw_addr_r <= awaddr_in;
         end
         if (wvalid_in && wready_out)
         begin
            wready_out <= 1'b0;
            w_data_r <= wdata_in;
            w_strb_r <= wstrb_in;
         end
         if (do_write)
         begin
            awready_out <= 1'b1;
            wready_out <= 1'b1;
            bvalid_out <= 1'b1;
            bresp_out <= (aw_addr_r == CFG_OFS || aw_addr_r == CMD_OFS ||
               aw_addr_r == STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_out && bready_in)
            bvalid_out <= 1'b0;
      end
   end

   // register storage
   // auto scan is the reset default
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         config_word_r <= CFG_RESET;
         command_word_r <= '0;
      end
      else if (do_write)
      begin
         if (aw_addr_r == CFG_OFS)
            config_word_r <= apply_strb(config_word_r, w_data_r, w_strb_r)
               & CFG_WMASK;
         if (cmd_wr)
            command_word_r <= w_data_r[CMD_CHAN_LSB +: CHAN_W];
      end
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         arready_out <= 1'b1;
         rvalid_out <= 1'b0;
         rdata_out <= '0;
         rresp_out <= RESP_OKAY;
      end
      else if (arvalid_in && arready_out)
      begin
         arready_out <= 1'b0;
         rvalid_out <= 1'b1;
         rresp_out <= RESP_OKAY;
         rdata_out <= '0;
         unique case (araddr_in)
            CFG_OFS: rdata_out <= config_word_r;
            CMD_OFS: rdata_out <= {29'h0, command_word_r};
            STAT_OFS:
            begin
               rdata_out[STAT_BUSY_POS] <= (state_r == ST_CONV);
               rdata_out[STAT_READY_POS] <= (state_r == ST_READY);
               rdata_out[STAT_CUR_LSB +: CHAN_W] <= chan_out;
               rdata_out[STAT_LAST_LSB +: CHAN_W] <= last_chan_r;
               rdata_out[STAT_CNT_LSB +: CNT_W] <= conv_count_r;
            end
            default: rresp_out <= RESP_SLVERR;
         endcase
      end
      else if (rvalid_out && rready_in)
      begin
         rvalid_out <= 1'b0;
         arready_out <= 1'b1;
      end
   end

   // slow rate stretches acquisition under auto trigger only, so starts are 42 clocks apart
   assign acq_target = (!trig_manual && config_word_r[CFG_RATE_POS]) ?
      ACQ_SLOW_CCLKS : ACQ_CCLKS;
   assign conv_begin = (state_r == ST_READY) && (!trig_manual || start_fall);
   assign conv_end = (state_r == ST_CONV) && cc_if.tick &&
      (cnt_r == CONV_CCLKS - 5'h01);

   // conversion sequence
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         state_r <= ST_ACQ;
         cnt_r <= '0;
      end
      else
      begin
         unique case (state_r)
            ST_ACQ:
            begin
               if (cc_if.tick)
               begin
                  if (cnt_r + 5'h01 >= acq_target)
                  begin
                     state_r <= ST_READY;
                     cnt_r <= '0;
                  end
                  else
                     cnt_r <= cnt_r + 5'h01;
               end
            end
            ST_READY:
            begin
               if (conv_begin)
               begin
                  state_r <= ST_CONV;
                  cnt_r <= '0;
               end
            end
            ST_CONV:
            begin
               if (conv_end)
               begin
                  state_r <= ST_ACQ;
                  cnt_r <= '0;
               end
               else if (cc_if.tick)
                  cnt_r <= cnt_r + 5'h01;
            end
            default:
            begin
               state_r <= ST_ACQ;
               cnt_r <= '0;
            end
         endcase
      end
   end

   assign osc_run_nxt = !config_word_r[CFG_CLK_SRC_POS] &&
      (state_r != ST_READY || !trig_manual ||
       config_word_r[CFG_AUTO_SLEEP_POS]);

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         osc_run_out <= 1'b0;
         hold_out <= 1'b0;
         conv_done_out <= 1'b0;
      end
      else
      begin
         osc_run_out <= osc_run_nxt;
         hold_out <= conv_begin || (state_r == ST_CONV && !conv_end);
         conv_done_out <= conv_end;
      end
   end

   // conversion bookkeeping
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         conv_chan_r <= '0;
         last_chan_r <= '0;
         conv_count_r <= '0;
      end
      else
      begin
         if (conv_begin)
            conv_chan_r <= (chan_auto && !auto_prev_r) ? last_chan_r :
               chan_out;
         if (conv_end)
         begin
            last_chan_r <= conv_chan_r;
            conv_count_r <= conv_count_r + 16'h0001;
         end
      end
   end

   // channel selection
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         chan_out <= '0;
         scan_first_r <= '0;
         auto_prev_r <= 1'b1;
      end
      else
      begin
         auto_prev_r <= chan_auto;
         if (!chan_auto && cmd_wr)
            chan_out <= w_data_r[CMD_CHAN_LSB +: CHAN_W];
         else if (chan_auto && !auto_prev_r)
         begin
            chan_out <= last_chan_r;
            scan_first_r <= last_chan_r;
         end
         else if (chan_auto && conv_end)
            chan_out <= next_chan(chan_out, scan_first_r);
      end
   end

   conv_len_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (state_r == ST_CONV && !conv_end) |=> state_r == ST_CONV)
      else $error("conversion left before eighteen clocks");

   conv_end_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      conv_end |=> (state_r == ST_ACQ && cnt_r == 5'h00 && conv_done_out))
      else $error("conversion end not followed by acquisition");

   acq_min_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (state_r == ST_ACQ && !(cc_if.tick && cnt_r + 5'h01 >= acq_target))
      |=> state_r == ST_ACQ)
      else $error("acquisition cut short");

   man_start_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (state_r == ST_READY && trig_manual && start_fall)
      |=> (state_r == ST_CONV && hold_out))
      else $error("start pin edge did not begin conversion");

   man_wait_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (state_r == ST_READY && trig_manual && !start_fall)
      |=> state_r == ST_READY)
      else $error("manual trigger started without start pin");

   auto_start_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (state_r == ST_READY && !trig_manual) |=> state_r == ST_CONV)
      else $error("auto trigger did not start conversion");

   osc_gate_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (state_r == ST_CONV && !config_word_r[CFG_CLK_SRC_POS])
      |=> osc_run_out)
      else $error("oscillator stopped during conversion");

   chan_man_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (!chan_auto && cmd_wr)
      |=> chan_out == $past(w_data_r[CMD_CHAN_LSB +: CHAN_W]))
      else $error("manual channel write not applied");

   chan_wrap_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (chan_auto && auto_prev_r && conv_end && chan_out == CHAN_HI)
      |=> chan_out == $past(scan_first_r))
      else $error("scan did not wrap to first channel");

   chan_stop_a: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      (!chan_auto && !cmd_wr) |=> $stable(chan_out))
      else $error("channel moved with scan disabled");
endmodule // sar_conversion_sequencer

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
module host_model #(
   parameter int SCLK_HALF_NS = 100
) (
   input wire logic clk_in,
   input wire logic start_req_in,
   input wire logic sclk_en_in,
   output logic sample_start_n_out,
   output logic sclk_out,
   output logic frame_select_n_out
);
   initial
   begin
      sample_start_n_out = 1'b1;
      sclk_out = 1'b0;
      frame_select_n_out = 1'b1;
   end

   always @(posedge start_req_in)
   begin
      @(posedge clk_in);
      #3 sample_start_n_out = 1'b0;
      frame_select_n_out = ~frame_select_n_out;
      repeat (4) @(posedge clk_in);
      #3 sample_start_n_out = 1'b1;
   end

   // 200 ns period, idle low
   // edges kept off the sampling clock edge, stops low
   always
   begin
      wait (sclk_en_in);
      #3;
      while (sclk_en_in)
      begin
         #(SCLK_HALF_NS) sclk_out = 1'b1;
         #(SCLK_HALF_NS) sclk_out = 1'b0;
      end
   end
endmodule // host_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import sar_seq_pkg::*;
   logic clk_in, rstn_in, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, start_req, sclk_en;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic start_n, sclk, fsel_n, osc_run, conv_clock, hold, done;
   logic [CHAN_W-1:0] chan;
   int fail_count = 0, n_compared = 0, sclk_cnt, conv_clock_cnt, done_cnt = 0;

   sar_conversion_sequencer i_dut (.clk_in(clk_in), .rstn_in(rstn_in),
      .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
      .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid),
      .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
      .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
      .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
      .rvalid_out(rvalid), .rready_in(rready),
      .sample_start_n_in(start_n), .sclk_in(sclk),
      .frame_select_n_in(fsel_n), .osc_run_out(osc_run),
      .conv_clock_out(conv_clock), .hold_out(hold), .conv_done_out(done),
      .chan_out(chan));

   host_model i_host (.clk_in(clk_in), .start_req_in(start_req),
      .sclk_en_in(sclk_en), .sample_start_n_out(start_n),
      .sclk_out(sclk), .frame_select_n_out(fsel_n));

   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   always @(posedge sclk)
      if (hold === 1'b1)
         sclk_cnt++;
   always @(conv_clock)
      if (hold === 1'b1)
         conv_clock_cnt++;
   always @(posedge clk_in)
      if (done === 1'b1)
         done_cnt++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi,
      input string what);
      n_compared++;
      if (got < lo || got > hi)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %0d", $time, what, got);
      end
   endtask

   task automatic stop_test;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_in);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         n++;
      end
      while (bvalid !== 1'b1 && n < 40);
      bready <= 1'b0;
      chk(32'({bvalid, bresp}), 32'h4, "write resp");
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_in);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         n++;
      end
      while (rvalid !== 1'b1 && n < 40);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      chk(32'(rvalid), 32'h1, "read answer");
   endtask

   task automatic trig;
      @(posedge clk_in);
      start_req <= 1'b1;
      @(posedge clk_in);
      start_req <= 1'b0;
   endtask

   // wait for hold, time it, note its channel
   task automatic meas(output logic [CHAN_W-1:0] ch, output int gap,
      output int len);
      gap = 0;
      len = 0;
      sclk_cnt = 0;
      conv_clock_cnt = 0;
      while (hold !== 1'b1 && gap < 3000)
      begin
         @(posedge clk_in);
         gap++;
      end
      ch = chan;
      while (hold === 1'b1 && len < 3000)
      begin
         @(posedge clk_in);
         len++;
      end
      @(posedge clk_in);
   endtask

   task automatic halt_set(input logic [31:0] cmd, input logic [31:0] cfg);
      wr(CFG_OFS, 32'h0000_0200);
      repeat (80) @(posedge clk_in);
      wr(CMD_OFS, cmd);
      wr(CFG_OFS, cfg);
   endtask

   task automatic s_reset;
      logic [31:0] d;
      logic [1:0] r;
      rd(CFG_OFS, d, r);
      chk(d, 32'h0000_0A00, "cfg reset");
      rd(4'hC, d, r);
      chk(32'(r), 32'h2, "unmapped");
   endtask

   task automatic s_manual;
      logic [CHAN_W-1:0] ch;
      int g, l, d0;
      repeat (80) @(posedge clk_in);
      chk(32'(osc_run), 32'h0, "osc idle");
      d0 = done_cnt;
      trig;
      meas(ch, g, l);
      chk_rng(g, 1, 8, "start to hold");
      chk(32'(ch), 32'h0, "first chan");
      chk_rng(l, 51, 57, "conv length");
      chk_rng(done_cnt - d0, 1, 1, "done pulse");
      chk(32'(chan), 32'h1, "scan step");
      wr(CFG_OFS, 32'h0000_0A02);
      repeat (3) @(posedge clk_in);
      chk(32'(osc_run), 32'h1, "osc auto sleep");
   endtask

   task automatic s_auto;
      logic [CHAN_W-1:0] ch;
      int g, l;
      halt_set(32'h3, 32'h0);
      meas(ch, g, l);
      meas(ch, g, l);
      chk(32'(ch), 32'h3, "manual chan");
      chk_rng(g, 6, 12, "auto restart");
      chk(32'(osc_run), 32'h1, "osc auto");
      halt_set(32'h5, 32'h0);
      meas(ch, g, l);
      chk(32'(ch), 32'h5, "new chan");
      halt_set(32'h5, 32'h0000_0100);
      meas(ch, g, l);
      meas(ch, g, l);
      chk_rng(g, 69, 75, "slow restart");
      chk_rng(l, 51, 57, "auto conv length");
   endtask

   task automatic s_scan;
      logic [CHAN_W-1:0] ch;
      int g, l;
      halt_set(32'h2, 32'h0000_0800);
      for (int i = 0; i < 4; i++)
      begin
         meas(ch, g, l);
         chk(32'(ch), 32'((i == 3) ? 5 : 5 + i), "scan");
      end
      wr(CFG_OFS, 32'h0);
      meas(ch, g, l);
      meas(ch, g, l);
      chk(32'(ch), 32'h6, "scan stopped");
      halt_set(32'h7, 32'h0);
      meas(ch, g, l);
      halt_set(32'h7, 32'h0000_0800);
      meas(ch, g, l);
      meas(ch, g, l);
      chk(32'(ch), 32'h7, "scan at top");
   endtask

   task automatic s_serial;
      logic [CHAN_W-1:0] ch;
      int g, l;
      halt_set(32'h2, 32'h0000_0201);
      @(posedge clk_in);
      sclk_en <= 1'b1;
      repeat (200) @(posedge clk_in);
      trig;
      meas(ch, g, l);
      chk(32'(ch), 32'h2, "serial chan");
      chk_rng(sclk_cnt, 35, 37, "sclk rises");
      chk_rng(conv_clock_cnt, 34, 38, "conv_clock toggles");
      sclk_en <= 1'b0;
   endtask

   initial
   begin
      rstn_in = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      start_req = 1'b0;
      sclk_en = 1'b0;
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      s_reset;
      s_manual;
      s_auto;
      s_scan;
      s_serial;
      stop_test;
   end

   initial
   begin
      #400000;
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test;
   end
endmodule // tb_top
